// ### src/sserr_pkg.sv
// package with the register map, field positions and reset values of the sensor status and error bank
// Contract
// - fatal flag while not operational, reset-only clear
// - error code: 0x00 none, 0x01 bad config
// - fifo error bit 6, cleared on read
// - aux error bit 7, cleared on read
// - error register resets 0x00, read-only, bit5 reserved
// - status resets 0x10, bit 4 command ready
// - status bit 2 shows manual aux transfer
// - status bit 5 aux ready, cleared reading aux
// - status bit 7 accel ready, cleared reading accel
// - aux x/y/z 16-bit at 0x0A-0x0F, little endian
package sserr_pkg;
  // register indexes; byte address is four times the index
  localparam logic [5:0] SSERR_IDX_ERROR_REPORT = 6'h02;
  localparam logic [5:0] SSERR_IDX_SENSOR_FLAGS = 6'h03;
  localparam logic [5:0] SSERR_IDX_AUX_X_LOW    = 6'h0A;
  localparam logic [5:0] SSERR_IDX_AUX_X_HIGH   = 6'h0B;
  localparam logic [5:0] SSERR_IDX_AUX_Y_LOW    = 6'h0C;
  localparam logic [5:0] SSERR_IDX_AUX_Y_HIGH   = 6'h0D;
  localparam logic [5:0] SSERR_IDX_AUX_Z_LOW    = 6'h0E;
  localparam logic [5:0] SSERR_IDX_AUX_Z_HIGH   = 6'h0F;
  localparam logic [5:0] SSERR_IDX_IRQ_STATUS   = 6'h20;
  localparam logic [5:0] SSERR_IDX_IRQ_MASK     = 6'h21;

  // error_report fields
  localparam int SSERR_ERR_FATAL_BIT = 0;
  localparam int SSERR_ERR_CMD_BIT   = 1;
  localparam int SSERR_ERR_CODE_LSB  = 2;
  localparam int SSERR_ERR_CODE_W    = 3;
  localparam int SSERR_ERR_FIFO_BIT  = 6;
  localparam int SSERR_ERR_AUX_BIT   = 7;
  localparam logic [2:0] SSERR_CODE_NO_ERROR  = 3'h0;
  localparam logic [2:0] SSERR_CODE_ACC_ERROR = 3'h1;
  localparam logic [7:0] SSERR_ERR_RESET      = 8'h00;

  // sensor_flags fields
  localparam int SSERR_STAT_MANUAL_BIT   = 2;
  localparam int SSERR_STAT_CMD_RDY_BIT  = 4;
  localparam int SSERR_STAT_DRDY_AUX_BIT = 5;
  localparam int SSERR_STAT_DRDY_ACC_BIT = 7;
  localparam logic [7:0] SSERR_STAT_RESET = 8'h10;

  // interrupt status and mask layout
  localparam int SSERR_IRQ_W        = 6;
  localparam int SSERR_IRQ_FATAL    = 0;
  localparam int SSERR_IRQ_CMD_ERR  = 1;
  localparam int SSERR_IRQ_FIFO_ERR = 2;
  localparam int SSERR_IRQ_AUX_ERR  = 3;
  localparam int SSERR_IRQ_DRDY_AUX = 4;
  localparam int SSERR_IRQ_DRDY_ACC = 5;
  localparam logic [5:0] SSERR_IRQ_RESET = 6'h00;

  localparam logic [15:0] SSERR_SAMPLE_RESET = 16'h0000;
  localparam logic [31:0] SSERR_BUS_ZERO     = 32'h0000_0000;
endpackage : sserr_pkg

// ### src/sserr_regs.sv
// error report, status flags and auxiliary sample registers behind a classic wishbone slave
module sserr_regs
  import sserr_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  output logic                     irq_o,
  // internal sources
  input  wire logic                soft_reset_i,
  input  wire logic                operational_i,
  input  wire logic                accel_configuration_bad_i,
  input  wire logic                cmd_busy_i,
  input  wire logic                cmd_fail_i,
  input  wire logic                fifo_discard_i,
  input  wire logic                aux_i2c_error_i,
  input  wire logic                manual_secondary_transfer_active_i,
  input  wire logic                aux_sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] aux_x_i,
  input  wire logic [SAMPLE_W-1:0] aux_y_i,
  input  wire logic [SAMPLE_W-1:0] aux_z_i,
  input  wire logic                accel_sample_valid_i,
  input  wire logic                accel_data_read_i
);

  // bus answer, interrupt pin and register state not held in the flag instances
  logic                ack_q, ack_d;
  logic [31:0]         dat_q, dat_d;
  logic                irq_q, irq_d;
  logic                fatal_q, fatal_d;
  logic [2:0]          code_q, code_d;
  logic                cmd_rdy_q, cmd_rdy_d;
  logic                manual_q, manual_d;
  logic [5:0]          irq_stat_q, irq_stat_d;
  logic [5:0]          irq_mask_q, irq_mask_d;

  // outputs of the flag and sample instances
  logic                cmd_err, fifo_err, aux_err;
  logic                drdy_aux, drdy_acc;
  logic [SAMPLE_W-1:0] aux_x, aux_y, aux_z;

  // request decode and register views
  logic                sync_rst;
  logic                take;
  logic [5:0]          idx;
  logic                rd_err, rd_aux, wr_istat, wr_imask;
  logic [7:0]          err_byte, stat_byte;
  logic [5:0]          irq_evt, istat_clr;

  // soft reset is synchronous and restores exactly the power-on values
  assign sync_rst = rst_i | soft_reset_i;

  // a request is taken once, in the cycle before ack rises
  assign take     = cyc_i & stb_i & ~ack_q;
  assign idx      = adr_i[7:2];
  assign rd_err   = take & ~we_i & (idx == SSERR_IDX_ERROR_REPORT);
  assign rd_aux   = take & ~we_i & (idx >= SSERR_IDX_AUX_X_LOW) & (idx <= SSERR_IDX_AUX_Z_HIGH);
  assign wr_istat = take & we_i & sel_i[0] & (idx == SSERR_IDX_IRQ_STATUS);
  assign wr_imask = take & we_i & sel_i[0] & (idx == SSERR_IDX_IRQ_MASK);

  // register views; reserved bits read as zero
  always_comb begin
    err_byte = SSERR_ERR_RESET;
    err_byte[SSERR_ERR_FATAL_BIT] = fatal_q;
    err_byte[SSERR_ERR_CMD_BIT]   = cmd_err;
    err_byte[SSERR_ERR_CODE_LSB +: SSERR_ERR_CODE_W] = code_q;
    err_byte[SSERR_ERR_FIFO_BIT]  = fifo_err;
    err_byte[SSERR_ERR_AUX_BIT]   = aux_err;
    stat_byte = '0;
    stat_byte[SSERR_STAT_MANUAL_BIT]   = manual_q;
    stat_byte[SSERR_STAT_CMD_RDY_BIT]  = cmd_rdy_q;
    stat_byte[SSERR_STAT_DRDY_AUX_BIT] = drdy_aux;
    stat_byte[SSERR_STAT_DRDY_ACC_BIT] = drdy_acc;
  end

  // fatal flag and error code next values
  always_comb begin
    fatal_d = fatal_q | ~operational_i;
    code_d  = accel_configuration_bad_i ? SSERR_CODE_ACC_ERROR : SSERR_CODE_NO_ERROR;
  end

  // fatal flag and error code registers; only a reset clears the fatal flag
  always_ff @(posedge clk_i) begin
    if (sync_rst) begin
      fatal_q <= 1'b0;
      code_q  <= SSERR_CODE_NO_ERROR;
    end else begin
      fatal_q <= fatal_d;
      code_q  <= code_d;
    end
  end

  sserr_sticky_flag u_cmd_err (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .set_i  (cmd_fail_i),
    .clr_i  (rd_err),
    .flag_o (cmd_err)
  );

  sserr_sticky_flag u_fifo_err (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .set_i  (fifo_discard_i),
    .clr_i  (rd_err),
    .flag_o (fifo_err)
  );

  sserr_sticky_flag u_aux_err (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .set_i  (aux_i2c_error_i),
    .clr_i  (rd_err),
    .flag_o (aux_err)
  );

  // status levels follow their sources one cycle later
  always_comb begin
    cmd_rdy_d = ~cmd_busy_i;
    manual_d  = manual_secondary_transfer_active_i;
  end

  // status level registers; command ready resets high
  always_ff @(posedge clk_i) begin
    if (sync_rst) begin
      cmd_rdy_q <= SSERR_STAT_RESET[SSERR_STAT_CMD_RDY_BIT];
      manual_q  <= SSERR_STAT_RESET[SSERR_STAT_MANUAL_BIT];
    end else begin
      cmd_rdy_q <= cmd_rdy_d;
      manual_q  <= manual_d;
    end
  end

  // aux x sample, low byte at the lower index
  sserr_sample_reg #(
    .W (SAMPLE_W)
  ) u_aux_x (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .load_i (aux_sample_valid_i),
    .d_i    (aux_x_i),
    .q_o    (aux_x)
  );

  sserr_sample_reg #(
    .W (SAMPLE_W)
  ) u_aux_y (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .load_i (aux_sample_valid_i),
    .d_i    (aux_y_i),
    .q_o    (aux_y)
  );

  sserr_sample_reg #(
    .W (SAMPLE_W)
  ) u_aux_z (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .load_i (aux_sample_valid_i),
    .d_i    (aux_z_i),
    .q_o    (aux_z)
  );

  sserr_sticky_flag u_drdy_aux (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .set_i  (aux_sample_valid_i),
    .clr_i  (rd_aux),
    .flag_o (drdy_aux)
  );

  sserr_sticky_flag u_drdy_acc (
    .clk_i  (clk_i),
    .rst_i  (sync_rst),
    .set_i  (accel_sample_valid_i),
    .clr_i  (accel_data_read_i),
    .flag_o (drdy_acc)
  );

  // interrupt events are the rising conditions of each flag
  always_comb begin
    irq_evt = '0;
    irq_evt[SSERR_IRQ_FATAL]    = ~operational_i & ~fatal_q;
    irq_evt[SSERR_IRQ_CMD_ERR]  = cmd_fail_i;
    irq_evt[SSERR_IRQ_FIFO_ERR] = fifo_discard_i;
    irq_evt[SSERR_IRQ_AUX_ERR]  = aux_i2c_error_i;
    irq_evt[SSERR_IRQ_DRDY_AUX] = aux_sample_valid_i;
    irq_evt[SSERR_IRQ_DRDY_ACC] = accel_sample_valid_i;
    // write one to clear, a new event in the same cycle survives
    istat_clr  = wr_istat ? dat_i[5:0] : SSERR_IRQ_RESET;
    irq_stat_d = irq_evt | (irq_stat_q & ~istat_clr);
    irq_mask_d = wr_imask ? dat_i[5:0] : irq_mask_q;
    // registered so the pin never glitches
    irq_d      = |(irq_stat_d & irq_mask_d);
  end

  // interrupt registers; the pin itself comes straight from a flop
  always_ff @(posedge clk_i) begin
    if (sync_rst) begin
      irq_stat_q <= SSERR_IRQ_RESET;
      irq_mask_q <= SSERR_IRQ_RESET;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
    end
  end

  // bus answer: ack one cycle after take, then dropped for a cycle
  always_comb begin
    ack_d = take;
    dat_d = SSERR_BUS_ZERO;
    if (take && !we_i) begin
      case (idx)
        SSERR_IDX_ERROR_REPORT: dat_d[7:0] = err_byte;
        SSERR_IDX_SENSOR_FLAGS: dat_d[7:0] = stat_byte;
        SSERR_IDX_AUX_X_LOW:    dat_d[7:0] = aux_x[7:0];
        SSERR_IDX_AUX_X_HIGH:   dat_d[7:0] = aux_x[15:8];
        SSERR_IDX_AUX_Y_LOW:    dat_d[7:0] = aux_y[7:0];
        SSERR_IDX_AUX_Y_HIGH:   dat_d[7:0] = aux_y[15:8];
        SSERR_IDX_AUX_Z_LOW:    dat_d[7:0] = aux_z[7:0];
        SSERR_IDX_AUX_Z_HIGH:   dat_d[7:0] = aux_z[15:8];
        SSERR_IDX_IRQ_STATUS:   dat_d[5:0] = irq_stat_q;
        SSERR_IDX_IRQ_MASK:     dat_d[5:0] = irq_mask_q;
        default:                dat_d      = SSERR_BUS_ZERO;
      endcase
    end
  end

  // bus registers; read data is zero outside the ack cycle
  always_ff @(posedge clk_i) begin
    if (sync_rst) begin
      ack_q <= 1'b0;
      dat_q <= SSERR_BUS_ZERO;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // every output comes from a flop
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign irq_o = irq_q;

endmodule // sserr_regs

// clear-on-read flag: a set in the clearing cycle wins so no event is lost
module sserr_sticky_flag
  import sserr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  logic flag_q, flag_d;

  // next value: set beats clear
  always_comb begin
    flag_d = set_i | (flag_q & ~clr_i);
  end

  // state register; rst_i here already includes the soft reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule // sserr_sticky_flag

// one sample register of parameterised width, loaded on a valid pulse
module sserr_sample_reg
  import sserr_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] smp_q, smp_d;

  // hold the old sample until a new one is stored
  always_comb begin
    smp_d = load_i ? d_i : smp_q;
  end

  // state register; all bytes reset to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_q <= W'(SSERR_SAMPLE_RESET);
    end else begin
      smp_q <= smp_d;
    end
  end

  assign q_o = smp_q;

endmodule // sserr_sample_reg

// ### verification/sserr_checker.sv
// concurrent checks on the ports of the status and error bank
module sserr_checker
  import sserr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic        soft_reset_i,
  input wire logic        operational_i,
  input wire logic        accel_configuration_bad_i,
  input wire logic        cmd_busy_i,
  input wire logic        manual_secondary_transfer_active_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // clean-cycle history, so past samples never reach into a reset
  logic up_q;
  always_ff @(posedge clk_i) up_q <= !(rst_i || soft_reset_i);
  wire tk = cyc_i && stb_i && !ack_o && !we_i && up_q;
  wire re = tk && adr_i == 8'h08;
  wire rs = tk && adr_i == 8'h0C;
  property p_ack; cyc_i && stb_i && !ack_o && !soft_reset_i |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");
  property p_ack1; ack_o |=> !ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_fatal; re && $past(!operational_i) |=> dat_o[SSERR_ERR_FATAL_BIT]; endproperty
  a_fatal: assert property (p_fatal) else $error("fatal flag missing");
  property p_code;
    re |=> dat_o[4:2] == ($past(accel_configuration_bad_i, 2) ? SSERR_CODE_ACC_ERROR : SSERR_CODE_NO_ERROR);
  endproperty
  a_code: assert property (p_code) else $error("error code wrong");
  property p_rsvd; (re ##1 !dat_o[5]) or (rs ##1 dat_o[6] == 1'h0 && dat_o[3] == 1'h0 && dat_o[1:0] == 2'h0);
  endproperty
  a_rsvd: assert property (p_rsvd or !(re || rs)) else $error("reserved bit set");
  property p_rdy; rs |=> dat_o[SSERR_STAT_CMD_RDY_BIT] == !$past(cmd_busy_i, 2); endproperty
  a_rdy: assert property (p_rdy) else $error("command ready wrong");
  property p_man; rs |=> dat_o[2] == $past(manual_secondary_transfer_active_i, 2); endproperty
  a_man: assert property (p_man) else $error("manual transfer bit wrong");
  c_fatal: cover property (re ##1 dat_o[0]);
  c_irq: cover property ($rose(irq_o));
  c_b2b: cover property (ack_o ##2 (cyc_i && stb_i));
endmodule // sserr_checker
bind sserr_regs sserr_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .irq_o,
  .soft_reset_i, .operational_i, .accel_configuration_bad_i, .cmd_busy_i, .manual_secondary_transfer_active_i);

// ### verification/sserr_host.sv
// host model: classic wishbone master issuing single register accesses
module sserr_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, dat_o} = 43'h0;
  // request held until ack is sampled, then one idle cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output bit ok);
    ok = 1'b0;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h3, w, a, 24'h0, d};
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_i);
      ok = ack_i;
    end
    {cyc_o, stb_o} <= 2'h0;
    @(posedge clk_i);
  endtask
endmodule // sserr_host

// ### verification/test_sensor_status_error_regs.sv
// self-checking bench for the status and error bank
module test_sensor_status_error_regs
  import sserr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [10:0] src = 11'h002;  // internal sources, operational by default
  logic [15:0] smp [3] = '{16'h0, 16'h0, 16'h0};
  logic [31:0] expq [$];
  bit          ok;
  int          err_count = 0;
  int          n_checks = 0;
  sserr_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .irq_o,
    .soft_reset_i(src[0]), .operational_i(src[1]), .accel_configuration_bad_i(src[2]), .cmd_busy_i(src[3]),
    .cmd_fail_i(src[4]), .fifo_discard_i(src[5]), .aux_i2c_error_i(src[6]),
    .manual_secondary_transfer_active_i(src[7]), .aux_sample_valid_i(src[8]), .aux_x_i(smp[0]),
    .aux_y_i(smp[1]), .aux_z_i(smp[2]), .accel_sample_valid_i(src[9]), .accel_data_read_i(src[10]));
  sserr_host u_host (.clk_i, .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
    .dat_o(dat_i));
  always #5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read data is judged at the falling edge, once the ack edge has settled
  always @(negedge clk_i) if (ack_o === 1'h1 && we_i === 1'h0) chk(dat_o, expq.pop_front());
  task automatic close_out(input bit hung);
    if (hung) err_count++;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    u_host.access(1'h0, a, 8'h0, ok);
    if (!ok) close_out(1'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'h1, a, d, ok);
    if (!ok) close_out(1'h1);
  endtask
  task automatic pulse(input int b);
    src[b] <= 1'h1;
    @(posedge clk_i);
    src[b] <= 1'h0;
    @(posedge clk_i);
  endtask
  // irq is a registered level, so let two edges pass before looking
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
    @(posedge clk_i);
  endtask
  initial begin
    void'($urandom(32'h6C15));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h10);
    for (int i = 0; i < 6; i++) rd(8'h28 + 8'(4 * i), 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h08, 8'hFF);
    wr(8'h28, 8'h5A);
    rd(8'h08, 8'h00);
    rd(8'h28, 8'h00);
    $display("test reset values done");
    foreach (smp[i]) smp[i] <= 16'($urandom);
    pulse(8);
    rd(8'h0C, 8'h30);
    rd(8'h2C, smp[0][15:8]);
    rd(8'h0C, 8'h10);
    for (int i = 0; i < 6; i++) rd(8'h28 + 8'(4 * i), smp[i / 2][8 * (i % 2) +: 8]);
    pulse(9);
    rd(8'h0C, 8'h90);
    pulse(10);
    rd(8'h0C, 8'h10);
    $display("test data ready done");
    pulse(4);
    pulse(5);
    pulse(6);
    rd(8'h08, 8'hC2);
    rd(8'h08, 8'h00);
    src[2] <= 1'h1;
    src[3] <= 1'h1;
    src[7] <= 1'h1;
    @(posedge clk_i);
    rd(8'h08, 8'h04);
    rd(8'h0C, 8'h04);
    src[2] <= 1'h0;
    src[3] <= 1'h0;
    src[7] <= 1'h0;
    @(posedge clk_i);
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h10);
    $display("test error flags done");
    wr(8'h80, 8'h3F);
    wr(8'h84, 8'h04);
    pulse(5);
    irq_is(1'h1);
    rd(8'h80, 8'h04);
    rd(8'h08, 8'h40);
    wr(8'h84, 8'h00);
    irq_is(1'h0);
    wr(8'h84, 8'h04);
    wr(8'h80, 8'h04);
    irq_is(1'h0);
    $display("test interrupt done");
    src[1] <= 1'h0;
    @(posedge clk_i);
    rd(8'h08, 8'h01);
    src[1] <= 1'h1;
    @(posedge clk_i);
    rd(8'h08, 8'h01);
    rd(8'h08, 8'h01);
    pulse(0);
    rd(8'h08, 8'h00);
    $display("test fatal done");
    close_out(1'h0);
  end
endmodule // test_sensor_status_error_regs
